// *** core/slx_map.vh ***
// slx_map.vh: constants for the skip, lookup, zero-test and xor execution block
// assumes: included by bare name from the core files
`ifndef SLX_MAP_VH
`define SLX_MAP_VH
// ----------------------------------------
// operation codes on op_code
// ----------------------------------------
`define SLX_OP_NONE 4'h0
`define SLX_OP_SKIP_BIT_CLEAR 4'h1
`define SLX_OP_SKIP_BIT_SET 4'h2
`define SLX_OP_LOAD_ACC_SKIP_ZERO 4'h3
`define SLX_OP_SELF_MOVE_SKIP_ZERO 4'h4
`define SLX_OP_INC_TO_ACC_SKIP_ZERO 4'h5
`define SLX_OP_INC_IN_PLACE_SKIP_ZERO 4'h6
`define SLX_OP_DEC_TO_ACC_SKIP_ZERO 4'h7
`define SLX_OP_DEC_IN_PLACE_SKIP_ZERO 4'h8
`define SLX_OP_LOOKUP_TO_REG 4'h9
`define SLX_OP_LOOKUP_TO_ACCUMULATOR 4'ha
`define SLX_OP_ZERO_TEST 4'hb
`define SLX_OP_XOR_IMMEDIATE_ACC 4'hc
`define SLX_OP_XOR_REG_TO_ACC 4'hd
`define SLX_OP_XOR_REG_IN_PLACE 4'he
// ----------------------------------------
// apb register offsets (byte addresses)
// ----------------------------------------
`define SLX_ADDR_ACC 12'h000
`define SLX_ADDR_STATUS 12'h004
`define SLX_ADDR_PTR_HIGH 12'h008
`define SLX_ADDR_PTR_LOW 12'h00c
`define SLX_ADDR_RESULT_HIGH 12'h010
// ----------------------------------------
// fields and reset values
// ----------------------------------------
`define SLX_STATUS_ZERO_BIT 0
`define SLX_STATUS_BUSY_BIT 1
`define SLX_STATUS_SKIP_BIT 2
`define SLX_RST_ACC 8'h00
`define SLX_RST_PTR 8'h00
`define SLX_WORD_LOW_BITS 8
`define SLX_LOOKUP_CYCLES 2
`endif

// *** core/slx_alu.v ***
// slx_alu.v: combinational datapath for the skip, zero-test and xor operations
// assumes: operands arrive settled within the same clk_sys cycle
`timescale 1ns/1ns
`include "slx_map.vh"
module slx_alu
(
	input wire [3:0] op_code,
	input wire [7:0] reg_value,
	input wire [7:0] imm_value,
	input wire [2:0] bit_sel,
	input wire [7:0] acc_value,
	output reg [7:0] result,
	output reg to_acc,
	output reg to_reg,
	output reg skip,
	output reg zero_update,
	output reg known
);
	wire [7:0] inc_value;
	wire [7:0] dec_value;
	wire sel_bit;
	assign inc_value = reg_value + 8'h01;
	assign dec_value = reg_value - 8'h01;
	assign sel_bit = reg_value[bit_sel];
	// decode of result, destination, skip and flag effect
	always @*
	begin
		result = 8'h00;
		to_acc = 1'b0;
		to_reg = 1'b0;
		skip = 1'b0;
		zero_update = 1'b0;
		known = 1'b1;
		case (op_code)
			`SLX_OP_SKIP_BIT_CLEAR:
			begin
				skip = ~sel_bit;
			end
			`SLX_OP_SKIP_BIT_SET:
			begin
				skip = sel_bit;
			end
			`SLX_OP_LOAD_ACC_SKIP_ZERO:
			begin
				result = reg_value;
				to_acc = 1'b1;
				skip = (reg_value == 8'h00);
			end
			`SLX_OP_SELF_MOVE_SKIP_ZERO:
			begin
				result = reg_value;
				to_reg = 1'b1;
				skip = (reg_value == 8'h00);
			end
			`SLX_OP_INC_TO_ACC_SKIP_ZERO:
			begin
				result = inc_value;
				to_acc = 1'b1;
				skip = (inc_value == 8'h00);
			end
			`SLX_OP_INC_IN_PLACE_SKIP_ZERO:
			begin
				result = inc_value;
				to_reg = 1'b1;
				skip = (inc_value == 8'h00);
			end
			`SLX_OP_DEC_TO_ACC_SKIP_ZERO:
			begin
				result = dec_value;
				to_acc = 1'b1;
				skip = (dec_value == 8'h00);
			end
			`SLX_OP_DEC_IN_PLACE_SKIP_ZERO:
			begin
				result = dec_value;
				to_reg = 1'b1;
				skip = (dec_value == 8'h00);
			end
			`SLX_OP_ZERO_TEST:
			begin
				result = reg_value;
				to_reg = 1'b1;
				zero_update = 1'b1;
			end
			`SLX_OP_XOR_IMMEDIATE_ACC:
			begin
				result = imm_value ^ acc_value;
				to_acc = 1'b1;
				zero_update = 1'b1;
			end
			`SLX_OP_XOR_REG_TO_ACC:
			begin
				result = reg_value ^ acc_value;
				to_acc = 1'b1;
				zero_update = 1'b1;
			end
			`SLX_OP_XOR_REG_IN_PLACE:
			begin
				result = reg_value ^ acc_value;
				to_reg = 1'b1;
				zero_update = 1'b1;
			end
			default:
			begin
				known = 1'b0;
			end
		endcase
	end
endmodule

// *** core/slx_apb.v ***
// slx_apb.v: apb slave for the accumulator, status and lookup registers
// assumes: apb master on clk_sys; zero wait states; unmapped reads give zero with pslverr
`timescale 1ns/1ns
`include "slx_map.vh"
module slx_apb
(
	input wire clk_sys,
	input wire rst,
	input wire psel,
	input wire penable,
	input wire pwrite,
	input wire [11:0] paddr,
	input wire [31:0] pwdata,
	input wire [7:0] acc_value,
	input wire zero_flag,
	input wire busy,
	input wire last_skip,
	input wire [7:0] ptr_high,
	input wire [7:0] ptr_low,
	input wire [7:0] result_high,
	output wire pready,
	output reg [31:0] prdata,
	output wire pslverr,
	output wire wr_acc,
	output wire wr_status,
	output wire wr_ptr_high,
	output wire wr_ptr_low,
	output wire [7:0] wr_data
);
	wire access;
	wire mapped;
	reg [31:0] next_prdata;
	assign access = psel & penable;
	assign mapped = (paddr == `SLX_ADDR_ACC) | (paddr == `SLX_ADDR_STATUS) |
		(paddr == `SLX_ADDR_PTR_HIGH) | (paddr == `SLX_ADDR_PTR_LOW) | (paddr == `SLX_ADDR_RESULT_HIGH);
	assign pready = 1'b1;
	assign pslverr = access & ~mapped;
	assign wr_data = pwdata[7:0];
	// write strobes, one cycle at the access phase
	assign wr_acc = access & pwrite & (paddr == `SLX_ADDR_ACC);
	assign wr_status = access & pwrite & (paddr == `SLX_ADDR_STATUS);
	assign wr_ptr_high = access & pwrite & (paddr == `SLX_ADDR_PTR_HIGH);
	assign wr_ptr_low = access & pwrite & (paddr == `SLX_ADDR_PTR_LOW);
	// read mux, registered at the setup phase so data stands in the access phase
	always @*
	begin
		next_prdata = 32'h00000000;
		case (paddr)
			`SLX_ADDR_ACC: next_prdata = {24'h000000, acc_value};
			`SLX_ADDR_STATUS: next_prdata = {29'h00000000, last_skip, busy, zero_flag};
			`SLX_ADDR_PTR_HIGH: next_prdata = {24'h000000, ptr_high};
			`SLX_ADDR_PTR_LOW: next_prdata = {24'h000000, ptr_low};
			`SLX_ADDR_RESULT_HIGH: next_prdata = {24'h000000, result_high};
			default: next_prdata = 32'h00000000;
		endcase
	end
	always @(posedge clk_sys or posedge rst)
	begin
		if (rst)
			prdata <= 32'h00000000;
		else if (psel & ~penable & ~pwrite)
			prdata <= next_prdata;
	end
endmodule

// *** core/slx_core.v ***
// slx_core.v: execution of skip, table lookup, zero-test and xor instructions
// assumes: a sequencer presents one instruction per op_valid pulse and waits for op_ready;
// the data register file answers reads combinationally; program memory answers in the pm_rd cycle
//
// The implementer's own choices: register access over APB and the register offsets.
`timescale 1ns/1ns
`include "slx_map.vh"
module slx_core
(
	input wire clk_sys,
	input wire rst,
	input wire psel,
	input wire penable,
	input wire pwrite,
	input wire [11:0] paddr,
	input wire [31:0] pwdata,
	output wire pready,
	output wire [31:0] prdata,
	output wire pslverr,
	input wire op_valid,
	input wire [3:0] op_code,
	input wire [2:0] op_bit,
	input wire [7:0] op_imm,
	output wire op_ready,
	output reg op_done,
	output reg op_skip,
	output reg op_error,
	input wire [7:0] reg_rdata,
	output reg reg_we,
	output reg [7:0] reg_wdata,
	output reg [10:0] pm_addr,
	output reg pm_rd,
	input wire [15:0] pm_rdata
);
	// ----------------------------------------
	// state
	// ----------------------------------------
	localparam ST_IDLE = 2'd0;
	localparam ST_TABLE = 2'd1;
	localparam ST_DISCARD = 2'd2;
	reg [1:0] state;
	reg [1:0] next_state;
	reg [7:0] accumulator;
	reg zero_flag;
	reg [7:0] lookup_pointer_high;
	reg [7:0] lookup_pointer_low;
	reg [7:0] lookup_result_high;
	reg lookup_to_acc;
	reg last_skip;
	wire [7:0] alu_result;
	wire alu_to_acc;
	wire alu_to_reg;
	wire alu_skip;
	wire alu_zero_update;
	wire alu_known;
	wire wr_acc;
	wire wr_status;
	wire wr_ptr_high;
	wire wr_ptr_low;
	wire [7:0] wr_data;
	wire take;
	wire is_lookup;
	wire [15:0] lookup_addr_full;
	assign op_ready = (state == ST_IDLE);
	assign take = op_valid & op_ready;
	assign is_lookup = (op_code == `SLX_OP_LOOKUP_TO_REG) | (op_code == `SLX_OP_LOOKUP_TO_ACCUMULATOR);
	// pointer high gives upper address bits, pointer low the lower byte
	assign lookup_addr_full = {lookup_pointer_high, lookup_pointer_low};

	// ----------------------------------------
	// datapath and register bus
	// ----------------------------------------
	slx_alu u_alu
	(
		.op_code(op_code),
		.reg_value(reg_rdata),
		.imm_value(op_imm),
		.bit_sel(op_bit),
		.acc_value(accumulator),
		.result(alu_result),
		.to_acc(alu_to_acc),
		.to_reg(alu_to_reg),
		.skip(alu_skip),
		.zero_update(alu_zero_update),
		.known(alu_known)
	);

	slx_apb u_apb
	(
		.clk_sys(clk_sys),
		.rst(rst),
		.psel(psel),
		.penable(penable),
		.pwrite(pwrite),
		.paddr(paddr),
		.pwdata(pwdata),
		.acc_value(accumulator),
		.zero_flag(zero_flag),
		.busy(~op_ready),
		.last_skip(last_skip),
		.ptr_high(lookup_pointer_high),
		.ptr_low(lookup_pointer_low),
		.result_high(lookup_result_high),
		.pready(pready),
		.prdata(prdata),
		.pslverr(pslverr),
		.wr_acc(wr_acc),
		.wr_status(wr_status),
		.wr_ptr_high(wr_ptr_high),
		.wr_ptr_low(wr_ptr_low),
		.wr_data(wr_data)
	);

	// ----------------------------------------
	// sequencing
	// ----------------------------------------
	// a skip holds one extra cycle in which the following instruction is dropped
	always @*
	begin
		next_state = state;
		case (state)
			ST_IDLE:
			begin
				if (take & is_lookup)
					next_state = ST_TABLE;
				else if (take & alu_known & alu_skip)
					next_state = ST_DISCARD;
			end
			ST_TABLE: next_state = ST_IDLE;
			ST_DISCARD: next_state = ST_IDLE;
			default: next_state = ST_IDLE;
		endcase
	end

	always @(posedge clk_sys or posedge rst)
	begin
		if (rst)
			state <= ST_IDLE;
		else
			state <= next_state;
	end

	// accumulator, zero flag, pointers and lookup result
	always @(posedge clk_sys or posedge rst)
	begin
		if (rst)
		begin
			accumulator <= `SLX_RST_ACC;
			zero_flag <= 1'b0;
			lookup_pointer_high <= `SLX_RST_PTR;
			lookup_pointer_low <= `SLX_RST_PTR;
			lookup_result_high <= 8'h00;
			lookup_to_acc <= 1'b0;
			last_skip <= 1'b0;
		end
		else
		begin
			if (wr_ptr_high)
				lookup_pointer_high <= wr_data;
			if (wr_ptr_low)
				lookup_pointer_low <= wr_data;
			if (wr_acc)
				accumulator <= wr_data;
			if (wr_status)
				zero_flag <= wr_data[`SLX_STATUS_ZERO_BIT];
			if (take & is_lookup)
				lookup_to_acc <= (op_code == `SLX_OP_LOOKUP_TO_ACCUMULATOR);
			if (take & alu_known & ~is_lookup)
			begin
				last_skip <= alu_skip;
				if (alu_to_acc)
					accumulator <= alu_result;
				if (alu_zero_update)
					zero_flag <= (alu_result == 8'h00);
			end
			if (state == ST_TABLE)
			begin
				lookup_result_high <= pm_rdata[15:`SLX_WORD_LOW_BITS];
				if (lookup_to_acc)
					accumulator <= pm_rdata[7:0];
			end
		end
	end

	// register file write, program memory read and completion outputs
	always @(posedge clk_sys or posedge rst)
	begin
		if (rst)
		begin
			reg_we <= 1'b0;
			reg_wdata <= 8'h00;
			pm_addr <= 11'h000;
			pm_rd <= 1'b0;
			op_done <= 1'b0;
			op_skip <= 1'b0;
			op_error <= 1'b0;
		end
		else
		begin
			reg_we <= 1'b0;
			pm_rd <= 1'b0;
			op_done <= 1'b0;
			op_skip <= 1'b0;
			op_error <= 1'b0;
			if (take & is_lookup)
			begin
				pm_addr <= lookup_addr_full[10:0];
				pm_rd <= 1'b1;
			end
			else if (take & alu_known)
			begin
				// register writes go out the cycle after the take
				reg_we <= alu_to_reg;
				reg_wdata <= alu_result;
				if (~alu_skip)
					op_done <= 1'b1;
			end
			else if (take)
			begin
				op_error <= 1'b1; // unknown code: ignored, no effect
				op_done <= 1'b1;
			end
			if (state == ST_TABLE)
			begin
				reg_we <= ~lookup_to_acc;
				reg_wdata <= pm_rdata[7:0];
				op_done <= 1'b1;
			end
			if (state == ST_DISCARD)
			begin
				op_done <= 1'b1; // second cycle: next instruction is dropped
				op_skip <= 1'b1;
			end
		end
	end
endmodule

// *** sim/slx_core_asserts.sv ***
// slx_core_asserts.sv: port checker for the instruction side of slx_core
// assumes: bound to slx_core; operation codes from slx_map.vh
`timescale 1ns/1ns
`include "slx_map.vh"
module slx_core_asserts
(
	input wire clk_sys,
	input wire rst,
	input wire op_valid,
	input wire [3:0] op_code,
	input wire [2:0] op_bit,
	input wire [7:0] reg_rdata,
	input wire op_ready,
	input wire op_done,
	input wire op_skip,
	input wire reg_we,
	input wire [7:0] reg_wdata,
	input wire pm_rd
);
	default clocking @(posedge clk_sys); endclocking
	default disable iff (rst);
	// instruction taken at this edge, and the tested bit
	wire tk = op_valid && op_ready;
	wire bt = reg_rdata[op_bit];
	wire lk = op_code == `SLX_OP_LOOKUP_TO_REG || op_code == `SLX_OP_LOOKUP_TO_ACCUMULATOR;
	AST_SKIP_DONE: assert property (op_skip |-> op_done) else $error("skip without done");
	AST_BIT_CLR: assert property (tk && op_code == `SLX_OP_SKIP_BIT_CLEAR && !bt
		|=> !op_ready ##1 op_done && op_skip) else $error("bit clear no skip");
	AST_BIT_SET: assert property (tk && op_code == `SLX_OP_SKIP_BIT_SET && bt
		|=> !op_ready ##1 op_done && op_skip) else $error("bit set no skip");
	AST_NO_SKIP: assert property (tk && op_code == `SLX_OP_SKIP_BIT_SET && !bt
		|=> op_done && !op_skip) else $error("skip not one cycle");
	AST_SELF_WB: assert property (tk && op_code == `SLX_OP_SELF_MOVE_SKIP_ZERO
		|=> reg_we && reg_wdata == $past(reg_rdata)) else $error("self move value");
	AST_INC_WB: assert property (tk && op_code == `SLX_OP_INC_IN_PLACE_SKIP_ZERO
		|=> reg_we && reg_wdata == $past(reg_rdata) + 8'h01) else $error("inc value");
	AST_DEC_WB: assert property (tk && op_code == `SLX_OP_DEC_IN_PLACE_SKIP_ZERO
		|=> reg_we && reg_wdata == $past(reg_rdata) - 8'h01) else $error("dec value");
	AST_LOOKUP: assert property (tk && lk |=> pm_rd && !op_ready ##[1:2] op_done)
		else $error("lookup timing");
	AST_ZT_WB: assert property (tk && op_code == `SLX_OP_ZERO_TEST
		|=> reg_we && op_done && reg_wdata == $past(reg_rdata)) else $error("zero test value");
	AST_XOR_IMM: assert property (tk && op_code == `SLX_OP_XOR_IMMEDIATE_ACC
		|=> op_done && !reg_we && !op_skip) else $error("xor immediate timing");
	// main scenarios
	COV_SKIP: cover property (op_skip);
	COV_LOOKUP: cover property (tk && lk);
	COV_XOR: cover property (tk && op_code == `SLX_OP_XOR_REG_IN_PLACE);
endmodule
bind slx_core slx_core_asserts u_chk (.clk_sys, .rst, .op_valid, .op_code, .op_bit, .reg_rdata,
	.op_ready, .op_done, .op_skip, .reg_we, .reg_wdata, .pm_rd);

// *** sim/slx_pm_model.sv ***
// slx_pm_model.sv: program memory and operand register behind slx_core
// assumes: clk_sys domain; bench preloads the operand register through ld
`timescale 1ns/1ns
module slx_pm_model
(
	input wire clk_sys,
	input wire ld,
	input wire [7:0] ld_val,
	input wire reg_we,
	input wire [7:0] reg_wdata,
	input wire pm_rd,
	input wire [10:0] pm_addr,
	output logic [7:0] reg_rdata = 8'h00,
	output logic [15:0] pm_rdata
);
	logic [15:0] idle_pattern = 16'ha5c3;
	// operand register: read at once, written at the edge
	always @(posedge clk_sys)
	begin
		if (ld)
			reg_rdata <= ld_val;
		else if (reg_we)
			reg_rdata <= reg_wdata;
	end
	// word stands in the cycle in which the strobe stands; a moving pattern otherwise
	assign pm_rdata = pm_rd ? {pm_addr[10:3], ~pm_addr[7:0]} : idle_pattern;
	always @(posedge clk_sys)
	begin
		idle_pattern <= ~idle_pattern;
	end
endmodule

// *** sim/slx_core_tb.sv ***
// slx_core_tb.sv: self-checking bench for slx_core
// assumes: slx_pm_model stands in for program memory and operand register
`timescale 1ns/1ns
`include "slx_map.vh"
module slx_core_tb;
	logic clk_sys = 1'b0;
	logic rst = 1'b1;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0;
	logic op_valid = 1'b0;
	logic [3:0] op_code = 4'h0;
	logic [2:0] op_bit = 3'h0;
	logic [7:0] op_imm = 8'h00;
	logic ld = 1'b0;
	logic [7:0] ld_val = 8'h00;
	wire pready, pslverr, op_ready, op_done, op_skip, op_error, reg_we, pm_rd;
	wire [31:0] prdata;
	wire [7:0] reg_rdata, reg_wdata;
	wire [10:0] pm_addr;
	wire [15:0] pm_rdata;
	logic [31:0] rd;
	logic er, skp, wb, s, oe;
	logic [7:0] wd, r, v;
	logic [3:0] c;
	logic [2:0] b;
	logic [10:0] a;
	int cyc, failures = 0, tests_run = 0;
	logic [3:0] tc [12] = '{4'h1, 4'h1, 4'h2, 4'h2, 4'h3, 4'h3, 4'h4, 4'h4, 4'h5, 4'h6, 4'h7, 4'h8};
	logic [7:0] tr [12] = '{8'h08, 8'hf7, 8'h80, 8'h7f, 8'h00, 8'h05, 8'h00, 8'h81, 8'hff, 8'hfe, 8'h01, 8'h00};
	always #4 clk_sys = ~clk_sys;
	slx_core u_dut (.clk_sys, .rst, .psel, .penable, .pwrite, .paddr, .pwdata, .pready, .prdata, .pslverr,
		.op_valid, .op_code, .op_bit, .op_imm, .op_ready, .op_done, .op_skip, .op_error, .reg_rdata,
		.reg_we, .reg_wdata, .pm_addr, .pm_rd, .pm_rdata);
	slx_pm_model u_pm (.clk_sys, .ld, .ld_val, .reg_we, .reg_wdata, .pm_rd, .pm_addr, .reg_rdata, .pm_rdata);
	// ----------------------------------------
	// access tasks
	// ----------------------------------------
	task chk(input string n, input logic [31:0] e, input logic [31:0] g);
		tests_run++;
		if (g !== e)
		begin
			failures++;
			$display("[ERR] %s expected %h seen %h", n, e, g);
		end
	endtask
	task apb(input logic w, input logic [11:0] ad, input logic [31:0] d);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= ad;
		pwdata <= d;
		@(posedge clk_sys);
		penable <= 1'b1;
		do
			@(posedge clk_sys);
		while (pready !== 1'b1);
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge clk_sys);
	endtask
	task zchk(input logic z);
		apb(1'b0, `SLX_ADDR_STATUS, 32'h0);
		chk("zero flag", {31'h0, z}, rd & 32'h1);
	endtask
	// preload operand, present one instruction, follow it to op_done
	task run_op(input logic [3:0] oc, input logic [2:0] ob, input logic [7:0] oi, input logic [7:0] rv);
		ld <= 1'b1;
		ld_val <= rv;
		@(posedge clk_sys);
		ld <= 1'b0;
		op_valid <= 1'b1;
		op_code <= oc;
		op_bit <= ob;
		op_imm <= oi;
		cyc = 0;
		@(negedge clk_sys);
		while (op_ready !== 1'b1 && cyc < 9)
		begin
			@(negedge clk_sys);
			cyc++;
		end
		chk("op ready", 32'h1, {31'h0, op_ready});
		@(posedge clk_sys);
		op_valid <= 1'b0;
		cyc = 0;
		wb = 1'b0;
		wd = 8'h00;
		do
		begin
			@(negedge clk_sys);
			cyc++;
			if (reg_we === 1'b1)
			begin
				wb = 1'b1;
				wd = reg_wdata;
			end
		end
		while (op_done !== 1'b1 && cyc < 9);
		chk("op done", 32'h1, {31'h0, op_done});
		skp = op_skip;
		oe = op_error;
		@(posedge clk_sys);
	endtask
	task complete_run;
		$display("comparisons %0d mismatches %0d", tests_run, failures);
		if (failures == 0 && tests_run > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask
	// ----------------------------------------
	// test sequence
	// ----------------------------------------
	initial
	begin
		repeat (5) @(posedge clk_sys);
		rst <= 1'b0;
		@(posedge clk_sys);
		apb(1'b0, `SLX_ADDR_ACC, 32'h0);
		chk("acc reset", {24'h0, `SLX_RST_ACC}, rd);
		apb(1'b0, 12'h020, 32'h0);
		chk("unmapped error", 32'h1, {31'h0, er});
		apb(1'b1, `SLX_ADDR_STATUS, 32'h1);
		// every skip form; bit and move forms taken and not taken, inc and dec forms once each
		for (int k = 0; k < 12; k++)
		begin
			c = tc[k];
			r = tr[k];
			b = c[1] ? 3'h7 : 3'h3;
			v = (c == 4'h5 || c == 4'h6) ? r + 8'h01 : (c == 4'h7 || c == 4'h8) ? r - 8'h01 : r;
			s = (c == 4'h1) ? !r[b] : (c == 4'h2) ? r[b] : (v == 8'h00);
			run_op(c, b, 8'h00, r);
			chk("skip", {31'h0, s}, {31'h0, skp});
			chk("cycles", s ? 32'h2 : 32'h1, cyc);
			chk("write back", (c == 4'h4 || c == 4'h6 || c == 4'h8) ? {23'h0, 1'b1, v} : 32'h0, {wb, wd});
			chk("no error", 32'h0, {31'h0, oe});
			apb(1'b0, `SLX_ADDR_STATUS, 32'h0);
			chk("status", {29'h0, s, 1'b0, 1'b1}, rd);
			if (c == 4'h3 || c == 4'h5 || c == 4'h7)
			begin
				apb(1'b0, `SLX_ADDR_ACC, 32'h0);
				chk("acc", {24'h0, v}, rd);
			end
		end
		zchk(1'b1);
		// an unknown code ends in one cycle with an error and changes nothing
		run_op(4'hf, 3'h0, 8'h00, 8'h00);
		chk("unknown code", 32'h1, {31'h0, oe});
		chk("unknown cycles", 32'h1, cyc);
		chk("unknown wb", 32'h0, {wb, wd});
		zchk(1'b1);
		// table lookups; pointer-high bits above 2 are dropped
		apb(1'b1, `SLX_ADDR_PTR_HIGH, 32'hfd);
		apb(1'b1, `SLX_ADDR_PTR_LOW, 32'h15);
		a = 11'h515;
		run_op(`SLX_OP_LOOKUP_TO_REG, 3'h0, 8'h00, 8'h77);
		chk("lookup reg", {23'h0, 1'b1, ~a[7:0]}, {wb, wd});
		apb(1'b0, `SLX_ADDR_RESULT_HIGH, 32'h0);
		chk("lookup high", {24'h0, a[10:3]}, rd);
		apb(1'b1, `SLX_ADDR_PTR_LOW, 32'hff);
		a = 11'h5ff;
		run_op(`SLX_OP_LOOKUP_TO_ACCUMULATOR, 3'h0, 8'h00, 8'h77);
		chk("lookup wb", 32'h0, {31'h0, wb});
		apb(1'b0, `SLX_ADDR_ACC, 32'h0);
		chk("lookup acc", {24'h0, ~a[7:0]}, rd);
		apb(1'b0, `SLX_ADDR_RESULT_HIGH, 32'h0);
		chk("lookup high", {24'h0, a[10:3]}, rd);
		// xor group and zero test, zero flag toggling each step
		apb(1'b1, `SLX_ADDR_ACC, 32'h0a);
		run_op(`SLX_OP_XOR_IMMEDIATE_ACC, 3'h0, 8'h0f, 8'h00);
		zchk(1'b0);
		apb(1'b0, `SLX_ADDR_ACC, 32'h0);
		chk("xor imm", 32'h05, rd);
		run_op(`SLX_OP_XOR_IMMEDIATE_ACC, 3'h0, 8'h05, 8'h00);
		zchk(1'b1);
		run_op(`SLX_OP_XOR_REG_TO_ACC, 3'h0, 8'h00, 8'h3c);
		zchk(1'b0);
		apb(1'b0, `SLX_ADDR_ACC, 32'h0);
		chk("xor to acc", 32'h3c, rd);
		run_op(`SLX_OP_XOR_REG_IN_PLACE, 3'h0, 8'h00, 8'h3c);
		chk("xor in place", {23'h0, 1'b1, 8'h00}, {wb, wd});
		zchk(1'b1);
		run_op(`SLX_OP_ZERO_TEST, 3'h0, 8'h00, 8'h81);
		chk("zero test wb", {23'h0, 1'b1, 8'h81}, {wb, wd});
		zchk(1'b0);
		run_op(`SLX_OP_ZERO_TEST, 3'h0, 8'h00, 8'h00);
		zchk(1'b1);
		complete_run;
	end
	// watchdog against a hung handshake
	initial
	begin
		repeat (5000) @(posedge clk_sys);
		failures++;
		complete_run;
	end
endmodule
